// >>> logic/rtlc_pkg.sv
// shared constants and types for the reload timer with oscillator capture
package rtlc_pkg;

  // register offsets on the plain register port
  localparam logic [2:0] ADDR_CTRL = 3'h0;
  localparam logic [2:0] ADDR_RLD_LO = 3'h1;
  localparam logic [2:0] ADDR_RLD_HI = 3'h2;
  localparam logic [2:0] ADDR_CNT_LO = 3'h3;
  localparam logic [2:0] ADDR_CNT_HI = 3'h4;
  localparam logic [2:0] ADDR_CLKSEL = 3'h5;
  localparam logic [2:0] ADDR_IRQEN = 3'h6;
  localparam logic [2:0] ADDR_STATUS = 3'h7;

  // timer_control_register fields
  localparam int CTRL_HI_FLAG = 7;
  localparam int CTRL_LO_FLAG = 6;
  localparam int CTRL_LO_IEN = 5;
  localparam int CTRL_CAP_EN = 4;
  localparam int CTRL_SPLIT = 3;
  localparam int CTRL_RUN = 2;
  localparam int CTRL_XCLK_HI = 1;
  localparam int CTRL_XCLK_LO = 0;

  // clock_control_register fields
  localparam int CKSEL_HI = 1;
  localparam int CKSEL_LO = 0;
  // extended_irq_enable_register field
  localparam int IRQEN_TIMER = 0;
  // status field
  localparam int STAT_SYNC = 0;

  // external_clock_select codes
  localparam logic [1:0] XCLK_SYS12 = 2'h0;
  localparam logic [1:0] XCLK_EXT8 = 2'h1;
  localparam logic [1:0] XCLK_RSVD = 2'h2;
  localparam logic [1:0] XCLK_LFO8 = 2'h3;

  // value after reset of every byte register
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [7:0] BYTE_MAX = 8'hFF;

  // clock division counts
  localparam logic [3:0] SYS_DIV = 4'hC;
  localparam logic [2:0] PIN_DIV = 3'h7;
  // timer clocks during which the timer registers are unsafe after wake-up
  localparam logic [1:0] SYNC_TICKS = 2'h3;

  typedef enum logic [1:0] {
    SY_IDLE = 2'b01,
    SY_PEND = 2'b10
  } rtlc_sync_t;

endpackage

// >>> logic/rtlc_timer.sv
// reload timer with split mode, suspend wake-up and oscillator capture
//
// Summary of operation
// - timer is two byte counters; split bit picks 16-bit or two 8-bit.
// - clocks are system, system/12, external/8 and low-freq oscillator/8.
// - divided pin clocks synchronised normally, taken directly in suspend.
// - timer counts in suspend and its overflow wakes the device.
// - sync-pending held up to three timer clocks after foreign wake-up.
// - oscillator clock counts only while its own divider is one.
// - 16-bit rollover loads reload pair and sets high overflow flag.
// - 16-bit overflow requests interrupt when timer interrupts enabled.
// - low byte rollover also interrupts when low-byte enable is set.
// - in split mode each byte reloads from its own reload byte.
// - in split mode run bit gates only the high byte counter.
// - per-byte select 1 picks system clock, else external select field.
// - split mode sets high and low flags on their byte rollovers.
// - split mode interrupts on high, or either with low-byte enable.
// - flags are never cleared by hardware, only by software.
// - capture enable bit selects capture mode; split should stay zero.
// - oscillator falling edge copies count to reload and sets high flag.
// - capture timer clock follows low-byte select and external field.
// - capture edge requests an interrupt when timer interrupts enabled.
//
// Chosen here: strobed register access and the address map.
module rtlc_timer (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [2:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  input wire logic ext_clk_i,
  input wire logic lfo_i,
  input wire logic lfo_div_one_i,
  input wire logic suspend_i,
  output logic irq_o,
  output logic wake_o,
  output logic sync_pending_o
);

  // picks the tick of one byte counter from its select bit and the field
  function automatic logic sel_tick(input logic use_sys,
                                    input logic [1:0] xsel,
                                    input logic [3:0] t);
    logic r;
    r = 1'b0;
    if (use_sys) begin
      r = t[0];
    end else begin
      case (xsel)
        rtlc_pkg::XCLK_SYS12: r = t[1];
        rtlc_pkg::XCLK_EXT8: r = t[2];
        rtlc_pkg::XCLK_LFO8: r = t[3];
        default: r = 1'b0; // reserved code never ticks
      endcase
    end
    return r;
  endfunction

  // software visible state
  logic [7:0] cnt_lo;
  logic [7:0] cnt_hi;
  logic [7:0] rld_lo;
  logic [7:0] rld_hi;
  logic hi_flag;
  logic lo_flag;
  logic lo_ien;
  logic cap_en;
  logic split;
  logic run;
  logic [1:0] xclk;
  logic cksel_hi;
  logic cksel_lo;
  logic tmr_ien;

  // prescaler and pin clock state
  logic [3:0] pre_cnt;
  logic [2:0] sync_ff [2];
  logic lvl_f [2];
  logic [2:0] div_cnt [2];
  logic pin_tick [2];
  logic pin_fall [2];
  logic [1:0] pins;

  // suspend tracking
  logic susp_d;
  logic [1:0] sync_cnt;
  rtlc_pkg::rtlc_sync_t sync_st;
  rtlc_pkg::rtlc_sync_t next_sync_st;

  assign pins = {lfo_i, ext_clk_i};

  // pin clocks: three flops, filtered level changes when stages two and
  // three agree; in suspend the direct path skips the filter stage
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_pin
      logic rise_norm;
      logic rise_dir;
      logic rise_sel;
      assign rise_norm = (sync_ff[gi][1] == sync_ff[gi][2]) &
                         sync_ff[gi][2] & ~lvl_f[gi];
      assign rise_dir = sync_ff[gi][1] & ~sync_ff[gi][2];
      // in suspend a filtered rise still counts, so that a rise seen just
      // before suspend began is not lost
      assign rise_sel = suspend_i ? (rise_dir | rise_norm) :
                        rise_norm;
      assign pin_tick[gi] = rise_sel & (div_cnt[gi] == rtlc_pkg::PIN_DIV);
      // the capture edge always takes the filtered path, so a pin glitch
      // cannot overwrite the reload pair
      assign pin_fall[gi] = (sync_ff[gi][1] == sync_ff[gi][2]) &
                            ~sync_ff[gi][2] & lvl_f[gi];

      // synchroniser and divide-by-eight
      always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          sync_ff[gi] <= 3'h0;
          lvl_f[gi] <= 1'b0;
          div_cnt[gi] <= 3'h0;
        end else begin
          sync_ff[gi] <= {sync_ff[gi][1:0], pins[gi]};
          // a rise already taken on the direct path must not count again
          // through the filter when suspend ends
          if (suspend_i && rise_dir) begin
            lvl_f[gi] <= 1'b1;
          end else if (sync_ff[gi][1] == sync_ff[gi][2]) begin
            lvl_f[gi] <= sync_ff[gi][2];
          end
          if (rise_sel) begin
            div_cnt[gi] <= div_cnt[gi] + 3'h1;
          end
        end
      end
    end
  endgenerate

  // tick vector: {lfo/8, ext/8, sys/12, sys}
  // a wrong oscillator divider stops the count rather than miscount it
  logic sys12_tick;
  logic [3:0] ticks;
  assign sys12_tick = (pre_cnt == rtlc_pkg::SYS_DIV - 4'h1);
  assign ticks = {pin_tick[1] & lfo_div_one_i, pin_tick[0],
                  sys12_tick, 1'b1};

  // system clock divided by twelve
  // free running: the first tick after a select change may come early
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pre_cnt <= 4'h0;
    end else if (sys12_tick) begin
      pre_cnt <= 4'h0;
    end else begin
      pre_cnt <= pre_cnt + 4'h1;
    end
  end

  // per-byte clock and increment decode
  logic lo_tick;
  logic hi_tick;
  logic lo_inc;
  logic hi_inc;
  logic lo_ovf;
  logic hi_ovf;
  logic cap_evt;
  logic wake_evt;
  assign lo_tick = sel_tick(cksel_lo, xclk, ticks);
  assign hi_tick = sel_tick(cksel_hi, xclk, ticks);
  // 16-bit and capture modes both run from the low-byte clock
  assign lo_inc = split ? lo_tick : (run & lo_tick);
  assign hi_inc = split ? (run & hi_tick) :
                  (lo_inc & (cnt_lo == rtlc_pkg::BYTE_MAX));
  assign lo_ovf = lo_inc & (cnt_lo == rtlc_pkg::BYTE_MAX);
  assign hi_ovf = hi_inc & (cnt_hi == rtlc_pkg::BYTE_MAX);
  assign cap_evt = cap_en & pin_fall[1];
  // an overflow of the 16-bit counter, or of either byte in split mode, may end suspend
  assign wake_evt = hi_ovf | (split & lo_ovf);

  // register port write decode
  logic wr_ctrl;
  logic wr_rlo;
  logic wr_rhi;
  logic wr_clo;
  logic wr_chi;
  logic wr_cks;
  logic wr_ien;
  assign wr_ctrl = wr_i & (addr_i == rtlc_pkg::ADDR_CTRL);
  assign wr_rlo = wr_i & (addr_i == rtlc_pkg::ADDR_RLD_LO);
  assign wr_rhi = wr_i & (addr_i == rtlc_pkg::ADDR_RLD_HI);
  assign wr_clo = wr_i & (addr_i == rtlc_pkg::ADDR_CNT_LO);
  assign wr_chi = wr_i & (addr_i == rtlc_pkg::ADDR_CNT_HI);
  assign wr_cks = wr_i & (addr_i == rtlc_pkg::ADDR_CLKSEL);
  assign wr_ien = wr_i & (addr_i == rtlc_pkg::ADDR_IRQEN);

  // next counter values; in capture mode a rollover wraps to zero because
  // the reload pair holds the captured value, not a reload value
  logic [7:0] next_cnt_lo;
  logic [7:0] next_cnt_hi;
  logic [7:0] lo_wrap;
  logic [7:0] hi_wrap;
  assign lo_wrap = (split | ~cap_en) ?
                   (split | hi_ovf ? rld_lo : 8'h00) : 8'h00;
  assign hi_wrap = cap_en & ~split ? 8'h00 : rld_hi;
  assign next_cnt_lo = wr_clo ? wdata_i :
                       lo_inc ? (cnt_lo == rtlc_pkg::BYTE_MAX ? lo_wrap :
                                 cnt_lo + 8'h01) : cnt_lo;
  assign next_cnt_hi = wr_chi ? wdata_i :
                       hi_inc ? (hi_ovf ? hi_wrap : cnt_hi + 8'h01) :
                       cnt_hi;

  // counter bytes
  // a software write wins over an increment in the same cycle
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_lo <= rtlc_pkg::RST_BYTE;
      cnt_hi <= rtlc_pkg::RST_BYTE;
    end else begin
      cnt_lo <= next_cnt_lo;
      cnt_hi <= next_cnt_hi;
    end
  end

  // reload pair; a capture edge wins over a software write
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rld_lo <= rtlc_pkg::RST_BYTE;
      rld_hi <= rtlc_pkg::RST_BYTE;
    end else if (cap_evt) begin
      rld_lo <= cnt_lo;
      rld_hi <= cnt_hi;
    end else begin
      if (wr_rlo) begin
        rld_lo <= wdata_i;
      end
      if (wr_rhi) begin
        rld_hi <= wdata_i;
      end
    end
  end

  // flags: a hardware set wins over a software clear in the same cycle
  logic next_hi_flag;
  logic next_lo_flag;
  assign next_hi_flag = hi_ovf | cap_evt |
                        (wr_ctrl ? wdata_i[rtlc_pkg::CTRL_HI_FLAG] :
                         hi_flag);
  assign next_lo_flag = lo_ovf |
                        (wr_ctrl ? wdata_i[rtlc_pkg::CTRL_LO_FLAG] :
                         lo_flag);

  // control bits and flags
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hi_flag <= 1'b0;
      lo_flag <= 1'b0;
      lo_ien <= 1'b0;
      cap_en <= 1'b0;
      split <= 1'b0;
      run <= 1'b0;
      xclk <= rtlc_pkg::XCLK_SYS12;
    end else begin
      hi_flag <= next_hi_flag;
      lo_flag <= next_lo_flag;
      if (wr_ctrl) begin
        lo_ien <= wdata_i[rtlc_pkg::CTRL_LO_IEN];
        cap_en <= wdata_i[rtlc_pkg::CTRL_CAP_EN];
        split <= wdata_i[rtlc_pkg::CTRL_SPLIT];
        run <= wdata_i[rtlc_pkg::CTRL_RUN];
        xclk <= wdata_i[rtlc_pkg::CTRL_XCLK_HI:rtlc_pkg::CTRL_XCLK_LO];
      end
    end
  end

  // clock select and interrupt enable registers
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cksel_hi <= 1'b0;
      cksel_lo <= 1'b0;
      tmr_ien <= 1'b0;
    end else begin
      if (wr_cks) begin
        cksel_hi <= wdata_i[rtlc_pkg::CKSEL_HI];
        cksel_lo <= wdata_i[rtlc_pkg::CKSEL_LO];
      end
      if (wr_ien) begin
        tmr_ien <= wdata_i[rtlc_pkg::IRQEN_TIMER];
      end
    end
  end

  // level interrupt request, held while a flag it covers is set
  logic next_irq;
  assign next_irq = tmr_ien &
                    (hi_flag | (lo_ien & lo_flag));

  // wake request holds until suspend is left
  // a level, so a one-cycle overflow cannot slip past the wake logic
  logic next_wake;
  assign next_wake = suspend_i & (wake_o | wake_evt);

  // sync-pending sequence after a wake-up from another source
  logic susp_exit;
  assign susp_exit = susp_d & ~suspend_i & ~wake_o;
  always_comb begin
    next_sync_st = sync_st;
    case (sync_st)
      rtlc_pkg::SY_IDLE: begin
        if (susp_exit) begin
          next_sync_st = rtlc_pkg::SY_PEND;
        end
      end
      rtlc_pkg::SY_PEND: begin
        // a second foreign wake before the wait ends starts it over
        if (susp_exit) begin
          next_sync_st = rtlc_pkg::SY_PEND;
        end else if (lo_tick &&
                     sync_cnt == rtlc_pkg::SYNC_TICKS - 2'h1) begin
          next_sync_st = rtlc_pkg::SY_IDLE;
        end
      end
      default: next_sync_st = rtlc_pkg::SY_IDLE;
    endcase
  end

  // suspend edge, pending counter, status outputs
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      susp_d <= 1'b0;
      sync_cnt <= 2'h0;
      sync_st <= rtlc_pkg::SY_IDLE;
      sync_pending_o <= 1'b0;
      irq_o <= 1'b0;
      wake_o <= 1'b0;
    end else begin
      susp_d <= suspend_i;
      sync_st <= next_sync_st;
      sync_pending_o <= (next_sync_st == rtlc_pkg::SY_PEND);
      irq_o <= next_irq;
      wake_o <= next_wake;
      if (sync_st != rtlc_pkg::SY_PEND || susp_exit) begin
        sync_cnt <= 2'h0;
      end else if (lo_tick) begin
        sync_cnt <= sync_cnt + 2'h1;
      end
    end
  end

  // read selection; data stands only in the cycle after the strobe
  logic [7:0] rd_mux;
  logic [7:0] ctrl_rd;
  assign ctrl_rd = {hi_flag, lo_flag, lo_ien, cap_en, split, run, xclk};
  assign rd_mux = (addr_i == rtlc_pkg::ADDR_CTRL) ? ctrl_rd :
                  (addr_i == rtlc_pkg::ADDR_RLD_LO) ? rld_lo :
                  (addr_i == rtlc_pkg::ADDR_RLD_HI) ? rld_hi :
                  (addr_i == rtlc_pkg::ADDR_CNT_LO) ? cnt_lo :
                  (addr_i == rtlc_pkg::ADDR_CNT_HI) ? cnt_hi :
                  (addr_i == rtlc_pkg::ADDR_CLKSEL) ?
                    {6'h00, cksel_hi, cksel_lo} :
                  (addr_i == rtlc_pkg::ADDR_IRQEN) ? {7'h00, tmr_ien} :
                  {7'h00, sync_pending_o};

  // read data register
  // zero outside the answer so a stale byte never looks like a fresh read
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_o <= 8'h00;
    end else begin
      rdata_o <= rd_i ? rd_mux : 8'h00;
    end
  end

endmodule

// >>> sim/rtlc_timer_asserts.sv
// assertion checker for the reload timer, bound to its ports
module rtlc_timer_asserts (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [2:0] addr_i,
  input wire logic rd_i,
  input wire logic wr_i,
  input wire logic [7:0] rdata_o,
  input wire logic suspend_i,
  input wire logic irq_o,
  input wire logic wake_o,
  input wire logic sync_pending_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  // leaving suspend for a reason other than a timer overflow
  sequence s_foreign_wake;
    $fell(suspend_i) && !wake_o;
  endsequence
  sequence s_awake;
    !suspend_i ##1 !suspend_i;
  endsequence
  property p_reset_quiet;
    $rose(rst_n_i) |-> !irq_o && !wake_o && !sync_pending_o;
  endproperty
  property p_wake_cause;
    $rose(wake_o) |-> $past(suspend_i);
  endproperty
  property p_wake_hold;
    wake_o && suspend_i |=> wake_o;
  endproperty
  property p_wake_drop;
    s_awake |-> !wake_o;
  endproperty
  property p_sync_set;
    s_foreign_wake |=> sync_pending_o;
  endproperty
  property p_sync_cause;
    $rose(sync_pending_o) |-> $past(suspend_i, 2) && !$past(suspend_i);
  endproperty
  // flags only fall by a write, so the request only drops after one
  property p_irq_sticky;
    irq_o && !wr_i && !$past(wr_i) |=> irq_o;
  endproperty
  property p_status_read;
    rd_i && addr_i == rtlc_pkg::ADDR_STATUS |=>
      rdata_o[rtlc_pkg::STAT_SYNC] == $past(sync_pending_o);
  endproperty
  property p_rdata_idle;
    !rd_i |=> rdata_o == 8'h00;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet)
    else $error("outputs active right after reset");
  a_wake_cause: assert property (p_wake_cause)
    else $error("wake raised outside suspend");
  a_wake_hold: assert property (p_wake_hold)
    else $error("wake dropped during suspend");
  a_wake_drop: assert property (p_wake_drop)
    else $error("wake still high after suspend ended");
  a_sync_set: assert property (p_sync_set)
    else $error("sync pending not set after foreign wake");
  a_sync_cause: assert property (p_sync_cause)
    else $error("sync pending set without leaving suspend");
  a_irq_sticky: assert property (p_irq_sticky)
    else $error("interrupt dropped without a write");
  a_status_read: assert property (p_status_read)
    else $error("status read disagrees with sync pending");
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data not zero outside read answer");
endmodule

bind rtlc_timer rtlc_timer_asserts chk_u (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .rd_i(rd_i),
  .wr_i(wr_i), .rdata_o(rdata_o), .suspend_i(suspend_i), .irq_o(irq_o),
  .wake_o(wake_o), .sync_pending_o(sync_pending_o)
);

// >>> sim/tb.sv
// self-checking bench for the reload timer
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [2:0] addr_i = 3'h0;
  logic [7:0] wdata_i = 8'h00;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic ext_clk_i = 1'b0;
  logic lfo_i = 1'b0;
  logic lfo_div_one_i = 1'b1;
  logic suspend_i = 1'b0;
  logic [7:0] rdata_o;
  logic irq_o;
  logic wake_o;
  logic sync_pending_o;
  int fail_count = 0;
  int samples_checked = 0;
  int cyc = 0;
  logic [7:0] d;
  logic [7:0] r;
  logic [7:0] h;
  // count windows per select: sys/12, ext/8, reserved, lfo/8, lfo off
  logic [7:0] lo_exp [5] = '{8'h07, 8'h02, 8'h00, 8'h02, 8'h00};
  logic [7:0] hi_exp [5] = '{8'h0A, 8'h02, 8'h00, 8'h02, 8'h00};

  rtlc_timer dut_u (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .ext_clk_i(ext_clk_i),
    .lfo_i(lfo_i), .lfo_div_one_i(lfo_div_one_i), .suspend_i(suspend_i),
    .irq_o(irq_o), .wake_o(wake_o), .sync_pending_o(sync_pending_o)
  );

  initial begin
    forever #50 clk_i = ~clk_i;
  end

  task automatic test_done();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // a hang counts as a mismatch
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 5000) begin
      fail_count++;
      test_done();
    end
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  function automatic logic [7:0] rng(input logic [7:0] v, lo, hi);
    return (v >= lo && v <= hi) ? 8'h01 : 8'h00;
  endfunction

  // a leading edge keeps two strobes of back-to-back calls apart
  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= v;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask

  task automatic rd(input logic [2:0] a);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    @(negedge clk_i);
    d = rdata_o;
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk_i);
    @(negedge clk_i);
  endtask

  // both pin clocks toggle together, 3 cycles a level
  task automatic pulses(input int n);
    repeat (2 * n) begin
      repeat (3) @(posedge clk_i);
      ext_clk_i <= ~ext_clk_i;
      lfo_i <= ~lfo_i;
    end
  endtask

  initial begin
    void'($urandom(62364));
    repeat (2) @(posedge clk_i);
    rst_n_i <= 1'b1;
    for (int a = 0; a < 8; a++) begin
      rd(3'(a));
      chk(d, 8'h00);
    end
    repeat (4) begin
      h = 8'($urandom);
      wr(rtlc_pkg::ADDR_RLD_HI, h);
      rd(rtlc_pkg::ADDR_RLD_HI);
      chk(d, h);
    end
    // 16-bit rollover from all ones
    r = 8'($urandom) & 8'h7F;
    wr(rtlc_pkg::ADDR_RLD_LO, r);
    wr(rtlc_pkg::ADDR_CLKSEL, 8'h03);
    wr(rtlc_pkg::ADDR_IRQEN, 8'h01);
    wr(rtlc_pkg::ADDR_CNT_LO, 8'hFD);
    wr(rtlc_pkg::ADDR_CNT_HI, 8'hFF);
    wr(rtlc_pkg::ADDR_CTRL, 8'h04);
    wait_cyc(8);
    rd(rtlc_pkg::ADDR_CTRL);
    chk(d, 8'hC4);
    chk({7'h00, irq_o}, 8'h01);
    rd(rtlc_pkg::ADDR_CNT_HI);
    chk(d, h);
    rd(rtlc_pkg::ADDR_CNT_LO);
    chk(rng(d, r, r + 8'h30), 8'h01);
    wr(rtlc_pkg::ADDR_CNT_HI, 8'h00);
    // low byte rollover with and without its enable
    for (int k = 0; k < 2; k++) begin
      wr(rtlc_pkg::ADDR_CTRL, 8'h00);
      wait_cyc(2);
      chk({7'h00, irq_o}, 8'h00);
      wr(rtlc_pkg::ADDR_CNT_LO, 8'hFD);
      wr(rtlc_pkg::ADDR_CTRL, k ? 8'h04 : 8'h24);
      wait_cyc(8);
      rd(rtlc_pkg::ADDR_CTRL);
      chk(d, k ? 8'h44 : 8'h64);
      chk({7'h00, irq_o}, k ? 8'h00 : 8'h01);
    end
    // split mode, high byte stopped, then running
    r = 8'($urandom) & 8'h7F;
    wr(rtlc_pkg::ADDR_CTRL, 8'h08);
    wr(rtlc_pkg::ADDR_RLD_LO, r);
    wr(rtlc_pkg::ADDR_RLD_HI, 8'h00);
    wr(rtlc_pkg::ADDR_CNT_HI, 8'hFD);
    wr(rtlc_pkg::ADDR_CNT_LO, 8'hFD);
    wait_cyc(8);
    rd(rtlc_pkg::ADDR_CTRL);
    chk(d, 8'h48);
    chk({7'h00, irq_o}, 8'h00);
    rd(rtlc_pkg::ADDR_CNT_HI);
    chk(d, 8'hFD);
    rd(rtlc_pkg::ADDR_CNT_LO);
    chk(rng(d, r, r + 8'h30), 8'h01);
    wr(rtlc_pkg::ADDR_CTRL, 8'h68);
    wait_cyc(2);
    chk({7'h00, irq_o}, 8'h01);
    wr(rtlc_pkg::ADDR_CTRL, 8'h0C);
    wait_cyc(8);
    rd(rtlc_pkg::ADDR_CTRL);
    chk(d & 8'hBF, 8'h8C);
    chk({7'h00, irq_o}, 8'h01);
    rd(rtlc_pkg::ADDR_CNT_HI);
    chk(rng(d, 8'h00, 8'h10), 8'h01);
    // every external clock select code of the low byte
    wr(rtlc_pkg::ADDR_CLKSEL, 8'h00);
    for (int k = 0; k < 5; k++) begin
      wr(rtlc_pkg::ADDR_CTRL, 8'h00);
      lfo_div_one_i <= (k != 4);
      wr(rtlc_pkg::ADDR_CNT_LO, 8'h00);
      wr(rtlc_pkg::ADDR_CTRL, (k == 4) ? 8'h07 : 8'h04 | 8'(k));
      pulses(16);
      wait_cyc(8);
      wr(rtlc_pkg::ADDR_CTRL, 8'h00);
      rd(rtlc_pkg::ADDR_CNT_LO);
      chk(rng(d, lo_exp[k], hi_exp[k]), 8'h01);
    end
    // split mode with both bytes on the external clock field
    wr(rtlc_pkg::ADDR_CNT_HI, 8'h00);
    wr(rtlc_pkg::ADDR_CNT_LO, 8'h00);
    wr(rtlc_pkg::ADDR_CTRL, 8'h0D);
    pulses(16);
    wait_cyc(8);
    wr(rtlc_pkg::ADDR_CTRL, 8'h00);
    rd(rtlc_pkg::ADDR_CNT_HI);
    chk(d, 8'h02);
    rd(rtlc_pkg::ADDR_CNT_LO);
    chk(d, 8'h02);
    // capture on a falling oscillator edge
    wr(rtlc_pkg::ADDR_CLKSEL, 8'h01);
    wr(rtlc_pkg::ADDR_CNT_HI, 8'h00);
    wr(rtlc_pkg::ADDR_CNT_LO, 8'h00);
    wr(rtlc_pkg::ADDR_CTRL, 8'h14);
    pulses(1);
    wait_cyc(8);
    rd(rtlc_pkg::ADDR_CTRL);
    chk(d, 8'h94);
    chk({7'h00, irq_o}, 8'h01);
    rd(rtlc_pkg::ADDR_RLD_LO);
    chk(rng(d, 8'h01, 8'h28), 8'h01);
    rd(rtlc_pkg::ADDR_RLD_HI);
    chk(d, 8'h00);
    // overflow in suspend wakes the device
    wr(rtlc_pkg::ADDR_CTRL, 8'h00);
    wr(rtlc_pkg::ADDR_CNT_HI, 8'hFF);
    wr(rtlc_pkg::ADDR_CNT_LO, 8'hF0);
    wr(rtlc_pkg::ADDR_CTRL, 8'h04);
    suspend_i <= 1'b1;
    wait_cyc(30);
    chk({7'h00, wake_o}, 8'h01);
    @(posedge clk_i);
    suspend_i <= 1'b0;
    wait_cyc(3);
    chk({7'h00, wake_o}, 8'h00);
    chk({7'h00, sync_pending_o}, 8'h00);
    // foreign wake with a source that never ticks keeps sync pending
    wr(rtlc_pkg::ADDR_CTRL, 8'h02);
    wr(rtlc_pkg::ADDR_CLKSEL, 8'h00);
    suspend_i <= 1'b1;
    wait_cyc(4);
    @(posedge clk_i);
    suspend_i <= 1'b0;
    wait_cyc(3);
    chk({7'h00, sync_pending_o}, 8'h01);
    rd(rtlc_pkg::ADDR_STATUS);
    chk(d, 8'h01);
    wr(rtlc_pkg::ADDR_CLKSEL, 8'h01);
    wait_cyc(10);
    chk({7'h00, sync_pending_o}, 8'h00);
    // reset in mid-run clears every register again
    @(posedge clk_i);
    rst_n_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    rst_n_i <= 1'b1;
    for (int a = 0; a < 8; a++) begin
      rd(3'(a));
      chk(d, 8'h00);
    end
    test_done();
  end
endmodule
